// >>> verilog/spics_regs.vh
`ifndef SPICS_REGS_VH
`define SPICS_REGS_VH
// ***********************************************************
// register indexes (byte address = 4 * index)
// ***********************************************************
`define SPICS_IDX_CTRL      8'hD4
`define SPICS_IDX_STAT      8'hD5
`define SPICS_IDX_DATA      8'hD6
`define SPICS_IDX_IRQ_STAT  8'hD7
`define SPICS_IDX_IRQ_MASK  8'hD8
// ***********************************************************
// control register fields
// ***********************************************************
`define SPICS_CTRL_RST      8'h14
`define SPICS_C_RATE2       7
`define SPICS_C_ENABLE      6
`define SPICS_C_SS_DIS      5
`define SPICS_C_MASTER      4
`define SPICS_C_CLOCK_POLARITY        3
`define SPICS_C_CLOCK_PHASE        2
`define SPICS_C_RATE1       1
`define SPICS_C_RATE0       0
// ***********************************************************
// status register fields
// ***********************************************************
`define SPICS_S_DONE        7
`define SPICS_S_OVR         5
`define SPICS_S_MODE_FAULT_FLAG        4
`define SPICS_S_TXE         3
`define SPICS_S_UART_MODE_SELECT       2
`define SPICS_S_TXEIE       1
`define SPICS_S_MODE_FAULT_IRQ_ENABLE      0
// ***********************************************************
// interrupt status / mask fields
// ***********************************************************
`define SPICS_I_TXREQ       0
`define SPICS_I_MODFREQ     1
`define SPICS_I_OVR         2
// ***********************************************************
// bus answers and byte count
// ***********************************************************
`define SPICS_RESP_OKAY     2'b00
`define SPICS_RESP_SLVERR   2'b10
`define SPICS_BITS_PER_BYTE 4'h8
`endif

// >>> verilog/spics_rate_div.v
`timescale 1ns/100ps
`include "spics_regs.vh"

// half-period tick for the master serial clock
module spics_rate_div (
	input  wire       clk,
	input  wire       arst_n,
	input  wire       run,      // master transfer under way
	input  wire [2:0] code,     // rate select
	output reg        tick      // one-cycle pulse per half period
);
	reg  [6:0] cnt;            // cycles into the half period
	wire [6:0] half_m1;        // half period minus one
	wire       valid;          // codes 000 and 111 stop the clock

	assign valid   = (code != 3'h0) && (code != 3'h7);
	assign half_m1 = (7'h01 << code) - 7'h01;

	// ***********************************************************
	// counter: resets whenever the engine is idle so each
	// byte starts with a full half period
	// ***********************************************************
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt  <= 7'h00;
			tick <= 1'b0;
		end else if (!run || !valid) begin
			// invalid code leaves the clock stopped
			cnt  <= 7'h00;
			tick <= 1'b0;
		end else if (cnt == half_m1) begin
			cnt  <= 7'h00;
			tick <= 1'b1;
		end else begin
			cnt  <= cnt + 7'h01;
			tick <= 1'b0;
		end
	end
endmodule // spics_rate_div

// >>> verilog/spics_top.v
`timescale 1ns/100ps
`include "spics_regs.vh"

// Function
// - tx-empty flag set when buffer empty
// - tx request from tx-empty only when enabled
// - idle clock level follows clock polarity
// - phase picks leading or trailing sample edge
// - rate codes divide by 4..128, ends invalid
// - control register resets to 0x14
// - done flag set on byte completion
// - done cleared by data access after status read
// - overrun on byte while done set, keep old
// - overrun cleared by status read
// - status register bit layout
// - reserved status bit six reads zero
// - tx request from done only when enable clear
// - mode fault on select level contradicting role
module spics_top (
	input  wire        clk,
	input  wire        arst_n,
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        sck_in,
	output reg         sck_out,
	output reg         sck_oe,
	input  wire        mosi_in,
	output wire        mosi_out,
	output reg         mosi_oe,
	input  wire        miso_in,
	output wire        miso_out,
	output reg         miso_oe,
	input  wire        ss_n_in,
	output reg         irq
);
	// ***********************************************************
	// register decode helper
	// ***********************************************************
	function hit;
		input [11:0] addr;
		input [7:0]  idx;
		begin
			hit = (addr[11:2] == {2'b00, idx});
		end
	endfunction

	// ***********************************************************
	// state
	// ***********************************************************
	reg  [7:0]  ctrl;          // serial interface control
	reg         done_flag;     // byte complete
	reg         ovr_flag;      // overrun
	reg         mode_fault_flag_flag;     // mode fault
	reg         txe_flag;      // transmit buffer empty
	reg  [2:0]  stat_wr;       // uart mode, tx-empty ie, mode_fault_flag ie
	reg         clr_armed;     // status read seen with done set
	reg  [7:0]  tx_buf;        // transmit buffer
	reg  [7:0]  rx_data;       // last received byte
	reg  [7:0]  shreg;         // shift register, msb goes out
	reg         latch;         // sampled bit awaiting shift
	reg  [3:0]  bit_cnt;       // samples taken this byte
	reg         busy;          // transfer under way
	reg         phase;         // master clock away from idle
	reg         sck_prev;      // last slave clock level
	reg  [2:0]  irq_stat;      // sticky events
	reg  [2:0]  irq_mask;      // event enables
	reg         txreq_prev;    // last tx request level
	reg         modreq_prev;   // last mode-fault request level
	reg         aw_got;        // write address held
	reg         w_got;         // write data held
	reg  [11:0] aw_addr;       // held write address
	reg  [7:0]  w_byte;        // held write data, low lane
	reg         w_lane;        // low byte lane enabled

	wire        en       = ctrl[`SPICS_C_ENABLE];
	wire        master   = ctrl[`SPICS_C_MASTER];
	wire        clock_polarity     = ctrl[`SPICS_C_CLOCK_POLARITY];
	wire        clock_phase     = ctrl[`SPICS_C_CLOCK_PHASE];
	wire        ss_dis   = ctrl[`SPICS_C_SS_DIS];
	wire [2:0]  rate     = {ctrl[`SPICS_C_RATE2], ctrl[`SPICS_C_RATE1],
	                        ctrl[`SPICS_C_RATE0]};
	wire        txeie    = stat_wr[1];
	wire        mode_fault_irq_enable   = stat_wr[0];
	wire        tick;
	wire        sdi      = master ? miso_in : mosi_in;
	wire        sel      = ss_dis | ~ss_n_in;
	wire [7:0]  stat_val;
	wire        wr_go    = aw_got & w_got & ~s_axi_bvalid;
	wire        rd_go    = s_axi_arvalid & s_axi_arready;
	wire        wr_ctrl  = wr_go & w_lane & hit(aw_addr, `SPICS_IDX_CTRL);
	wire        wr_stat  = wr_go & w_lane & hit(aw_addr, `SPICS_IDX_STAT);
	wire        wr_data  = wr_go & w_lane & hit(aw_addr, `SPICS_IDX_DATA);
	wire        wr_mask  = wr_go & w_lane & hit(aw_addr, `SPICS_IDX_IRQ_MASK);
	wire        rd_stat  = rd_go & hit(s_axi_araddr, `SPICS_IDX_STAT);
	wire        rd_data  = rd_go & hit(s_axi_araddr, `SPICS_IDX_DATA);
	wire        rd_irq   = rd_go & hit(s_axi_araddr, `SPICS_IDX_IRQ_STAT);
	wire        m_lead   = tick & ~phase;
	wire        m_trail  = tick & phase;
	wire        s_edge   = busy & ~master & (sck_in != sck_prev);
	wire        lead     = master ? m_lead : (s_edge & (sck_in != clock_polarity));
	wire        trail    = master ? m_trail : (s_edge & (sck_in == clock_polarity));
	wire        fault    = en & ~ss_dis & ~ss_n_in & master
	                     | en & ~ss_dis & ss_n_in & ~master & busy;
	wire        complete = ~fault & trail &
	                       (clock_phase ? (bit_cnt == `SPICS_BITS_PER_BYTE - 4'h1)
	                             : (bit_cnt == `SPICS_BITS_PER_BYTE));
	wire [7:0]  rx_byte  = {shreg[6:0], clock_phase ? sdi : latch};
	wire        tx_req   = txeie ? txe_flag : done_flag;
	wire        mod_req  = mode_fault_flag_flag & mode_fault_irq_enable;
	wire [2:0]  events   = {complete & done_flag, mod_req & ~modreq_prev,
	                        tx_req & ~txreq_prev};
	wire        next_irq = |(irq_stat & irq_mask);

	// status layout, reserved bit six reads as zero
	assign stat_val = {done_flag, 1'b0, ovr_flag, mode_fault_flag_flag, txe_flag,
	                   stat_wr};
	assign mosi_out = shreg[7];
	assign miso_out = shreg[7];

	// ***********************************************************
	// master clock divider
	// ***********************************************************
	spics_rate_div u_div (
		.clk    (clk),
		.arst_n (arst_n),
		.run    (busy & master),
		.code   (rate),
		.tick   (tick)
	);

	// ***********************************************************
	// bus write channels: address and data taken in any order
	// ***********************************************************
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_got        <= 1'b0;
			w_got         <= 1'b0;
			aw_addr       <= 12'h000;
			w_byte        <= 8'h00;
			w_lane        <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SPICS_RESP_OKAY;
		end else begin
			// ready only while nothing is held, so a beat is never lost
			s_axi_awready <= ~aw_got & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready  <= ~w_got & ~(s_axi_wvalid & s_axi_wready);
			if (s_axi_awvalid & s_axi_awready) begin
				aw_got  <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_got  <= 1'b1;
				w_byte <= s_axi_wdata[7:0];
				w_lane <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				if (hit(aw_addr, `SPICS_IDX_CTRL) | hit(aw_addr, `SPICS_IDX_STAT) |
				    hit(aw_addr, `SPICS_IDX_DATA) | hit(aw_addr, `SPICS_IDX_IRQ_STAT) |
				    hit(aw_addr, `SPICS_IDX_IRQ_MASK)) begin
					s_axi_bresp <= `SPICS_RESP_OKAY;
				end else begin
					s_axi_bresp <= `SPICS_RESP_SLVERR;
				end
			end else if (s_axi_bvalid & s_axi_bready) begin
				// response taken: free both holding slots
				s_axi_bvalid <= 1'b0;
				aw_got       <= 1'b0;
				w_got        <= 1'b0;
			end
		end
	end

	// ***********************************************************
	// bus read channel: one-cycle answer
	// ***********************************************************
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `SPICS_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~rd_go;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `SPICS_RESP_OKAY;
				if (hit(s_axi_araddr, `SPICS_IDX_CTRL)) begin
					s_axi_rdata <= {24'h00_0000, ctrl};
				end else if (hit(s_axi_araddr, `SPICS_IDX_STAT)) begin
					s_axi_rdata <= {24'h00_0000, stat_val};
				end else if (hit(s_axi_araddr, `SPICS_IDX_DATA)) begin
					s_axi_rdata <= {24'h00_0000, rx_data};
				end else if (hit(s_axi_araddr, `SPICS_IDX_IRQ_STAT)) begin
					s_axi_rdata <= {29'h0000_0000, irq_stat};
				end else if (hit(s_axi_araddr, `SPICS_IDX_IRQ_MASK)) begin
					s_axi_rdata <= {29'h0000_0000, irq_mask};
				end else begin
					// unmapped: zero data and slave error
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `SPICS_RESP_SLVERR;
				end
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ***********************************************************
	// software registers and status flags (set beats clear)
	// ***********************************************************
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl      <= `SPICS_CTRL_RST;
			stat_wr   <= 3'h0;
			irq_mask  <= 3'h0;
			done_flag <= 1'b0;
			ovr_flag  <= 1'b0;
			mode_fault_flag_flag <= 1'b0;
			clr_armed <= 1'b0;
			rx_data   <= 8'h00;
		end else begin
			if (wr_ctrl) begin
				ctrl <= w_byte;
			end
			if (wr_stat) begin
				stat_wr <= w_byte[2:0];
			end
			if (wr_mask) begin
				irq_mask <= w_byte[2:0];
			end
			// arm the done clear only from a status read that saw it set
			if (rd_stat) begin
				clr_armed <= done_flag;
			end else if (rd_data | wr_data) begin
				clr_armed <= 1'b0;
			end
			if (complete & ~done_flag) begin
				done_flag <= 1'b1;
				rx_data   <= rx_byte;
			end else if (clr_armed & (rd_data | wr_data)) begin
				done_flag <= 1'b0;
			end
			// old byte kept: an overrun always means data lost
			if (complete & done_flag) begin
				ovr_flag <= 1'b1;
			end else if (rd_stat) begin
				ovr_flag <= 1'b0;
			end
			if (fault) begin
				mode_fault_flag_flag <= 1'b1;
			end else if (rd_stat) begin
				mode_fault_flag_flag <= 1'b0;
			end
		end
	end

	// ***********************************************************
	// transmit buffer and tx-empty flag
	// ***********************************************************
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_buf   <= 8'h00;
			txe_flag <= 1'b1;
		end else if (wr_data) begin
			tx_buf   <= w_byte;
			txe_flag <= 1'b0;
		end else if (~busy & en & ~fault & (master | sel)) begin
			// buffer moves to the shifter at byte start
			txe_flag <= 1'b1;
		end
	end

	// ***********************************************************
	// shift engine shared by master and slave
	// ***********************************************************
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busy    <= 1'b0;
			phase   <= 1'b0;
			shreg   <= 8'h00;
			latch   <= 1'b0;
			bit_cnt <= 4'h0;
		end else if (fault | ~en) begin
			// abort: drop the byte in flight
			busy    <= 1'b0;
			phase   <= 1'b0;
			bit_cnt <= 4'h0;
		end else if (~busy) begin
			phase   <= 1'b0;
			bit_cnt <= 4'h0;
			if (master ? ~txe_flag : sel) begin
				busy  <= 1'b1;
				shreg <= txe_flag ? shreg : tx_buf;
			end
		end else begin
			if (master & tick) begin
				phase <= ~phase;
			end
			if (lead) begin
				if (!clock_phase) begin
					latch   <= sdi;
					bit_cnt <= bit_cnt + 4'h1;
				end else if (bit_cnt != 4'h0) begin
					shreg <= {shreg[6:0], latch};
				end
			end
			if (trail) begin
				if (clock_phase) begin
					latch   <= sdi;
					bit_cnt <= bit_cnt + 4'h1;
				end else begin
					shreg <= {shreg[6:0], latch};
				end
			end
			if (complete) begin
				busy  <= 1'b0;
				shreg <= rx_byte;
			end
		end
	end

	// ***********************************************************
	// pin drivers
	// ***********************************************************
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sck_out  <= 1'b0;
			sck_oe   <= 1'b0;
			mosi_oe  <= 1'b0;
			miso_oe  <= 1'b0;
			sck_prev <= 1'b0;
		end else begin
			sck_prev <= sck_in;
			// idle level equals polarity, phase flips it
			sck_out  <= clock_polarity ^ (phase & ~(master & tick)) ^ (master & tick & ~phase);
			sck_oe   <= en & master & ~mode_fault_flag_flag;
			mosi_oe  <= en & master & ~mode_fault_flag_flag;
			miso_oe  <= en & ~master & sel;
		end
	end

	// ***********************************************************
	// interrupt: sticky events, read clears, set wins
	// ***********************************************************
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_stat    <= 3'h0;
			txreq_prev  <= 1'b0;
			modreq_prev <= 1'b0;
			irq         <= 1'b0;
		end else begin
			txreq_prev  <= tx_req;
			modreq_prev <= mod_req;
			irq_stat    <= (rd_irq ? 3'h0 : irq_stat) | events;
			irq         <= next_irq;
		end
	end
endmodule // spics_top

// >>> tb/spics_props.sv
`timescale 1ns/100ps
// ***********************************************************
// port checker for the spi control block
// ***********************************************************
module spics_props (
	input wire        clk,
	input wire        arst_n,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        sck_out,
	input wire        sck_oe,
	input wire        mosi_oe,
	input wire        miso_oe,
	input wire        ss_n_in,
	input wire        irq
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// answers stand until the master takes them
	a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped early");
	// write answer two cycles after both beats are taken, read answer one
	a_w_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write answer late");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	// no new request taken while an answer is pending
	a_b_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	a_r_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	// fastest rate is four cycles a period, so no half period under two cycles
	a_sck_half_min: assert property (sck_oe && $changed(sck_out) |=> $stable(sck_out))
		else $error("serial clock half period too short");
	// a low select while master must take the clock driver off
	a_fault_release: assert property ((!ss_n_in) [*4] |-> !sck_oe)
		else $error("clock still driven under mode fault");
	// slave output never fights the master drivers
	a_one_driver: assert property (miso_oe |-> !mosi_oe && !sck_oe)
		else $error("master and slave drivers both on");

	cover property (s_axi_rvalid && s_axi_rready);
	cover property (sck_oe && $changed(sck_out));
	cover property ($rose(irq));
endmodule // spics_props

// >>> tb/spics_spi_peer.sv
`timescale 1ns/100ps
// ***********************************************************
// external slave peripheral on the serial side
// ***********************************************************
module spics_spi_peer (
	input  wire       sck,      // clock from the master
	input  wire       mosi,     // data from the master
	input  wire       clock_polarity,     // idle clock level
	input  wire       clock_phase,     // sample on trailing edge when set
	input  wire       sel,      // frame active
	input  wire [7:0] tx_byte,  // byte to return
	output reg        miso,     // data to the master
	output reg  [7:0] rx_byte   // byte received
);
	reg [7:0] sh;     // frozen copy of the byte to send
	integer   idx;    // next bit to present, msb first
	reg       sel_q;  // select level at the last wake-up

	// one process owns every output, so no level has two drivers
	initial begin
		miso = 1'b0;
		rx_byte = 8'h00;
		sh = 8'h00;
		idx = 0;
		sel_q = 1'b0;
		forever begin
			@(sel or sck);
			if (sel && !sel_q) begin
				// load at frame start; trailing phase waits for the first edge
				sh = tx_byte;
				idx = clock_phase ? 7 : 6;
				miso = clock_phase ? ~tx_byte[7] : tx_byte[7];
			end else if (!sel && sel_q) begin
				// released line shows the inverse, never a stale level
				miso = ~miso;
			end else if (sel) begin
				// sample on one edge, shift on the other
				if ((sck ^ clock_polarity) ^ clock_phase) begin
					rx_byte = {rx_byte[6:0], mosi};
				end else if (idx >= 0) begin
					miso = sh[idx];
					idx = idx - 1;
				end else begin
					miso = ~miso;
				end
			end
			sel_q = sel;
		end
	end
endmodule // spics_spi_peer

// >>> tb/spics_top_test.sv
`timescale 1ns/100ps
`include "spics_regs.vh"
// ***********************************************************
// bench top
// ***********************************************************
module spics_top_test;
	reg         clk, arst_n, ss_n_in;
	reg  [11:0] s_axi_awaddr, s_axi_araddr;
	reg  [31:0] s_axi_wdata;
	reg  [3:0]  s_axi_wstrb;
	reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire        sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, irq, miso_in;
	wire        sck_in = sck_oe ? sck_out : 1'b0;    // pin level seen back
	wire        mosi_in = mosi_oe ? mosi_out : 1'b0; // pin level seen back
	reg         peer_clock_polarity, peer_clock_phase, peer_sel, sck_q;
	reg  [7:0]  peer_tx;
	wire [7:0]  peer_rx;
	reg  [31:0] rd;                                  // last read data
	reg  [1:0]  rs;                                  // last response
	integer     num_errors, n_checks, cycles, n_tog, run_len, last_half, i, t0;

	spics_top u_dut (.*);
	spics_spi_peer u_peer (.sck(sck_out), .mosi(mosi_out), .clock_polarity(peer_clock_polarity), .clock_phase(peer_clock_phase),
		.sel(peer_sel), .tx_byte(peer_tx), .miso(miso_in), .rx_byte(peer_rx));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// half period and edge count of the serial clock, one cycle late
	always @(posedge clk) begin
		sck_q <= sck_out;
		if (sck_out !== sck_q) begin
			last_half <= run_len;
			run_len <= 1;
			n_tog <= n_tog + 1;
		end else begin
			run_len <= run_len + 1;
		end
	end

	// a hang ends the run as a failure
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			num_errors = num_errors + 1;
			wrap_up;
		end
	end

	task wrap_up;
		begin
			if (num_errors == 0 && n_checks > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask

	task chk_val(input [31:0] got, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask

	task chk_resp(input [1:0] got, input [1:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask

	// one bus access; each channel released at its own handshake
	task bus(input wr, input [7:0] idx, input [7:0] val, input [3:0] strb);
		begin
			@(posedge clk);
			if (wr) begin
				s_axi_awaddr <= {2'b00, idx, 2'b00};
				s_axi_wdata <= {24'h00_0000, val};
				s_axi_wstrb <= strb;
				s_axi_awvalid <= 1'b1;
				s_axi_wvalid <= 1'b1;
				s_axi_bready <= 1'b1;
			end else begin
				s_axi_araddr <= {2'b00, idx, 2'b00};
				s_axi_arvalid <= 1'b1;
				s_axi_rready <= 1'b1;
			end
			begin : wait_ans
				forever begin
					@(posedge clk);
					if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
					if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
					if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
					if (wr && s_axi_bvalid === 1'b1) begin
						rs = s_axi_bresp;
						s_axi_bready <= 1'b0;
						disable wait_ans;
					end
					if (!wr && s_axi_rvalid === 1'b1) begin
						rs = s_axi_rresp;
						rd = s_axi_rdata;
						s_axi_rready <= 1'b0;
						disable wait_ans;
					end
				end
			end
		end
	endtask

	task wr(input [7:0] idx, input [7:0] val);
		begin
			bus(1'b1, idx, val, 4'hf);
			chk_resp(rs, `SPICS_RESP_OKAY);
		end
	endtask

	task rd_chk(input [7:0] idx, input [7:0] exp);
		begin
			bus(1'b0, idx, 8'h00, 4'h0);
			chk_resp(rs, `SPICS_RESP_OKAY);
			chk_val(rd, {24'h00_0000, exp});
		end
	endtask

	task wait_irq;
		begin
			while (irq !== 1'b1) @(posedge clk);
		end
	endtask

	// one master byte against the peer
	task xfer(input [2:0] code, input [1:0] mode, input [7:0] db, input [7:0] pb);
		begin
			wr(`SPICS_IDX_CTRL, {code[2], 2'b10, 1'b1, mode, code[1:0]});
			// a polarity change must pass before the peer is selected
			repeat (4) @(posedge clk);
			peer_clock_polarity <= mode[1];
			peer_clock_phase <= mode[0];
			peer_tx <= pb;
			peer_sel <= 1'b1;
			t0 = n_tog;
			wr(`SPICS_IDX_DATA, db);
			rd = 32'h0000_0000;
			while (rd[7] !== 1'b1) bus(1'b0, `SPICS_IDX_STAT, 8'h00, 4'h0);
			// edge count trails the flag by a cycle, the interrupt by two
			@(posedge clk);
			chk_val(rd, 32'h0000_0088);
			chk_val({sck_oe, mosi_oe, miso_oe}, 3'b110);
			chk_val(n_tog - t0, 16);
			chk_val(last_half, 1 << code);
			chk_val(sck_out, mode[1]);
			chk_val(irq, 1);
			chk_val(peer_rx, db);
			rd_chk(`SPICS_IDX_DATA, pb);
			rd_chk(`SPICS_IDX_STAT, 8'h08);
			rd_chk(`SPICS_IDX_IRQ_STAT, 8'h01);
			peer_sel <= 1'b0;
		end
	endtask

	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
		{peer_clock_polarity, peer_clock_phase, peer_sel, sck_q, peer_tx} = 0;
		{num_errors, n_checks, cycles, n_tog, run_len, last_half} = 0;
		rd = 0;
		rs = 0;
		ss_n_in = 1'b1;
		arst_n = 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		rd_chk(`SPICS_IDX_CTRL, `SPICS_CTRL_RST);
		rd_chk(`SPICS_IDX_STAT, 8'h08);
		bus(1'b0, 8'hD9, 8'h00, 4'h0);
		chk_resp(rs, `SPICS_RESP_SLVERR);
		chk_val(rd, 32'h0000_0000);
		bus(1'b1, 8'hD9, 8'h5A, 4'hf);
		chk_resp(rs, `SPICS_RESP_SLVERR);
		bus(1'b1, `SPICS_IDX_CTRL, 8'hFF, 4'h0);
		chk_resp(rs, `SPICS_RESP_OKAY);
		rd_chk(`SPICS_IDX_CTRL, `SPICS_CTRL_RST);
		wr(`SPICS_IDX_STAT, 8'hB4);
		rd_chk(`SPICS_IDX_STAT, 8'h0C);
		// enabled request stays off the pin while masked
		wr(`SPICS_IDX_STAT, 8'h02);
		repeat (2) @(posedge clk);
		chk_val(irq, 0);
		wr(`SPICS_IDX_IRQ_MASK, 8'h07);
		repeat (2) @(posedge clk);
		chk_val(irq, 1);
		rd_chk(`SPICS_IDX_IRQ_STAT, 8'h01);
		repeat (2) @(posedge clk);
		chk_val(irq, 0);
		wr(`SPICS_IDX_STAT, 8'h00);
		for (i = 1; i < 7; i = i + 1)
			xfer(i[2:0], i[1:0], 8'hA5 ^ i[7:0], 8'h3C ^ i[7:0]);
		// second byte lands while the first is unread
		wr(`SPICS_IDX_CTRL, 8'h51);
		{peer_clock_polarity, peer_clock_phase} <= 2'b00;
		peer_tx <= 8'h5A;
		@(posedge clk);
		peer_sel <= 1'b1;
		wr(`SPICS_IDX_DATA, 8'h11);
		wait_irq;
		rd_chk(`SPICS_IDX_IRQ_STAT, 8'h01);
		peer_sel <= 1'b0;
		peer_tx <= 8'hC3;
		@(posedge clk);
		peer_sel <= 1'b1;
		wr(`SPICS_IDX_DATA, 8'h22);
		wait_irq;
		rd_chk(`SPICS_IDX_STAT, 8'hA8);
		rd_chk(`SPICS_IDX_IRQ_STAT, 8'h04);
		rd_chk(`SPICS_IDX_DATA, 8'h5A);
		rd_chk(`SPICS_IDX_STAT, 8'h08);
		peer_sel <= 1'b0;
		// select pulled low under an enabled master
		wr(`SPICS_IDX_STAT, 8'h01);
		ss_n_in <= 1'b0;
		repeat (4) @(posedge clk);
		chk_val(sck_oe, 0);
		ss_n_in <= 1'b1;
		rd_chk(`SPICS_IDX_STAT, 8'h19);
		rd_chk(`SPICS_IDX_IRQ_STAT, 8'h02);
		rd_chk(`SPICS_IDX_STAT, 8'h09);
		// selected slave loses its select after its byte starts, before any clock edge
		wr(`SPICS_IDX_CTRL, 8'h40);
		ss_n_in <= 1'b0;
		repeat (2) @(posedge clk);
		chk_val({sck_oe, mosi_oe, miso_oe}, 3'b001);
		ss_n_in <= 1'b1;
		rd_chk(`SPICS_IDX_STAT, 8'h19);
		rd_chk(`SPICS_IDX_IRQ_STAT, 8'h02);
		wrap_up;
	end
endmodule // spics_top_test

bind spics_top spics_props u_props (.clk(clk), .arst_n(arst_n), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sck_out(sck_out), .sck_oe(sck_oe),
	.mosi_oe(mosi_oe), .miso_oe(miso_oe), .ss_n_in(ss_n_in), .irq(irq));
